// ===== core/accel_out_pkg.sv
// shared constants and carrier types for the acceleration output register view
package accel_out_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_X_LOW = 8'h04;
    localparam logic [7:0] ADDR_X_HIGH = 8'h05;
    localparam logic [7:0] ADDR_Y_LOW = 8'h06;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h07;
    localparam logic [7:0] ADDR_Z_LOW = 8'h08;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h09;
    localparam logic [7:0] ADDR_QUEUE_STATE = 8'h0b;

    // sample and queue geometry
    localparam int SAMPLE_W = 12;
    localparam int COUNT_W = 6;
    localparam int AXIS_NUM = 3;
    localparam logic [COUNT_W-1:0] QUEUE_DEPTH = 6'h20;

    // queue state field layout and reset values
    localparam int WMRK_BIT = 7;
    localparam int OVF_BIT = 6;
    localparam int COUNT_MSB = 5;
    localparam logic [7:0] QUEUE_STATE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [1:0] QUEUE_MODE_OFF = 2'h0;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;

    typedef struct packed {
        logic [SAMPLE_W-1:0] z;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] x;
    } accel_triple_t;

    typedef struct packed {
        logic byte_order_select;       // 0 little-endian, 1 big-endian
        logic fast_read_select;        // upper-byte registers skipped on bursts
        logic [1:0] queue_mode;        // 00 disables the output queue
        logic [COUNT_W-1:0] watermark_level;
    } view_config_t;

    typedef struct packed {
        logic [7:0] low_byte;          // byte at the lower address
        logic [7:0] high_byte;         // byte at the next address
    } axis_bytes_t;

endpackage

// ===== core/axis_byte_format.sv
// byte layout of one 12-bit axis sample for the two register addresses
`timescale 1ns/1ps
module axis_byte_format
    import accel_out_pkg::*;
(
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic byte_order_select,
    input wire logic fast_read_select,
    output axis_bytes_t bytes
);

    logic sign_fill_bit;

    // sign fill always follows bit 11 of the sample
    // R08 sign fill source
    assign sign_fill_bit = sample[SAMPLE_W-1];

    // pick the layout: fast read forces bits 11:4 to the lower address
    always_comb begin
        if (fast_read_select) begin
            // R05 upper bits low address
            bytes.low_byte = sample[11:4];
            bytes.high_byte = {sample[3:0], NIBBLE_ZERO};
        end else if (byte_order_select) begin
            // R02 big-endian layout
            bytes.low_byte = sample[11:4];
            bytes.high_byte = {sample[3:0], NIBBLE_ZERO};
        end else begin
            // R01 little-endian layout
            bytes.low_byte = sample[7:0];
            bytes.high_byte = {{4{sign_fill_bit}}, sample[11:8]};
        end
    end

endmodule

// ===== core/accel_output_register_format.sv
// read-only register view of the latest xyz sample and the output queue state
`timescale 1ns/1ps
// Functional notes
// R01 - In little-endian order the lower address holds bits 7:0 and the next holds sign fill over bits 11:8.
// R02 - In big-endian order the lower address holds bits 11:4 and the next holds bits 3:0 over four zeros.
// R03 - While the queue mode is 00 the queue state register reads as zero.
// R04 - The queue state register resets to zero and holds watermark in bit 7, overflow in bit 6, count in 5:0.
// R05 - In fast-read mode burst auto-increment skips the upper-byte registers and the lower address holds bits 11:4.
// R06 - The watermark flag is set while the stored count is at or above the watermark level; the code keeps it clear while the queue mode is 00.
// R07 - A sample arriving with 32 stored keeps the count at 32 and sets the overflow flag.
// R08 - Every sign fill bit copies bit 11 of its axis sample.
// R09 - Host writes to these registers are ignored and change nothing.
module accel_output_register_format
    import accel_out_pkg::*;
#(
    parameter logic [COUNT_W-1:0] DEPTH = QUEUE_DEPTH
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input accel_triple_t sample_in,
    input view_config_t view_cfg,
    input wire logic queue_push,
    input wire logic queue_pop,
    input wire logic queue_flush,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic [7:0] reg_next_addr,
    output logic reg_wr_ack,
    output logic [COUNT_W-1:0] stored_sample_count,
    output logic watermark_flag,
    output logic queue_overflow_flag
);

    typedef struct packed {
        accel_triple_t sample;
        logic [COUNT_W-1:0] count;
        logic ovf;
        logic wmrk;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [7:0] next_addr;
        logic wr_ack;
    } view_state_t;

    localparam view_state_t STATE_RESET = '0;

    // push and pop seen on one edge
    typedef enum logic [1:0] {
        REQ_IDLE = 2'h0,
        REQ_POP = 2'h1,
        REQ_PUSH = 2'h2,
        REQ_BOTH = 2'h3
    } queue_req_t;

    view_state_t st_q;
    view_state_t st_d;
    logic [SAMPLE_W-1:0] axis_sample [AXIS_NUM];
    axis_bytes_t axis_bytes [AXIS_NUM];
    logic queue_off;
    logic [7:0] queue_state_byte;
    logic [7:0] addr_plus_one;
    logic [7:0] addr_plus_two;
    logic [7:0] mapped_byte;
    logic [7:0] burst_next_addr;
    logic next_is_upper;
    queue_req_t queue_req;
    logic queue_full;
    logic queue_empty;
    logic [COUNT_W-1:0] count_next;
    logic ovf_next;
    accel_triple_t sample_next;

    // samples in axis order for the formatters
    assign axis_sample[0] = st_q.sample.x;
    assign axis_sample[1] = st_q.sample.y;
    assign axis_sample[2] = st_q.sample.z;

    // one byte formatter per axis
    // formatters see the registered sample, so a read shows the last strobe
    genvar g;
    generate
        for (g = 0; g < AXIS_NUM; g = g + 1) begin : g_axis
            axis_byte_format u_fmt (
                .sample(axis_sample[g]),
                .byte_order_select(view_cfg.byte_order_select),
                .fast_read_select(view_cfg.fast_read_select),
                .bytes(axis_bytes[g])
            );
        end
    endgenerate

    // queue disable and the byte addresses one and two steps on
    assign queue_off = (view_cfg.queue_mode == QUEUE_MODE_OFF);
    assign addr_plus_one = reg_addr + 8'h01;
    assign addr_plus_two = reg_addr + 8'h02;

    // host queue request as push and pop bits
    assign queue_req = queue_req_t'({queue_push, queue_pop});

    // count end points against the configured depth
    assign queue_full = (st_q.count >= DEPTH);
    assign queue_empty = (st_q.count == '0);

    // all three axes latch together on the sample strobe
    assign sample_next = sample_valid ? sample_in : st_q.sample;

    // queue state byte as the host sees it
    always_comb begin
        queue_state_byte = QUEUE_STATE_RESET;
        // R04 field placement
        queue_state_byte[WMRK_BIT] = st_q.wmrk;
        queue_state_byte[OVF_BIT] = st_q.ovf;
        queue_state_byte[COUNT_MSB:0] = st_q.count;
        // R03 disabled reads zero
        if (queue_off) begin
            queue_state_byte = QUEUE_STATE_RESET;
        end
    end

    // stored count and overflow flag for the next edge
    always_comb begin
        count_next = st_q.count;
        ovf_next = st_q.ovf;
        if (queue_off || queue_flush) begin
            // disable or flush wins over push and pop
            count_next = '0;
            ovf_next = 1'b0;
        end else begin
            unique case (queue_req)
                REQ_PUSH: begin
                    if (queue_full) begin
                        // R07 saturate and flag
                        count_next = DEPTH;
                        ovf_next = 1'b1;
                    end else begin
                        count_next = st_q.count + 6'h01;
                    end
                end
                REQ_POP: begin
                    // a sample read out clears overflow
                    ovf_next = 1'b0;
                    if (!queue_empty) begin
                        count_next = st_q.count - 6'h01;
                    end
                end
                REQ_BOTH: begin
                    ovf_next = 1'b0; // one leaves as one enters
                end
                REQ_IDLE: begin
                    count_next = st_q.count;
                end
            endcase
        end
    end

    // byte selected by the host address
    always_comb begin
        unique case (reg_addr)
            ADDR_X_LOW: mapped_byte = axis_bytes[0].low_byte;
            ADDR_X_HIGH: mapped_byte = axis_bytes[0].high_byte;
            ADDR_Y_LOW: mapped_byte = axis_bytes[1].low_byte;
            ADDR_Y_HIGH: mapped_byte = axis_bytes[1].high_byte;
            ADDR_Z_LOW: mapped_byte = axis_bytes[2].low_byte;
            ADDR_Z_HIGH: mapped_byte = axis_bytes[2].high_byte;
            ADDR_QUEUE_STATE: mapped_byte = queue_state_byte;
            default: mapped_byte = UNMAPPED_READ;
        endcase
    end

    // R05 skip upper bytes
    assign next_is_upper = (addr_plus_one == ADDR_X_HIGH) ||
        (addr_plus_one == ADDR_Y_HIGH) || (addr_plus_one == ADDR_Z_HIGH);
    assign burst_next_addr = (view_cfg.fast_read_select && next_is_upper) ?
        addr_plus_two : addr_plus_one;

    // next state of the whole view
    always_comb begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        // R09 writes ignored
        st_d.wr_ack = reg_wr_en;

        // sample, stored count and overflow flag
        st_d.sample = sample_next;
        st_d.count = count_next;
        st_d.ovf = ovf_next;

        // R06 watermark compare
        st_d.wmrk = !queue_off && (count_next >= view_cfg.watermark_level);

        // register read data and auto-increment address
        if (reg_rd_en) begin
            st_d.rd_valid = 1'b1;
            st_d.rd_data = mapped_byte;
            st_d.next_addr = burst_next_addr;
        end
    end

    // register the whole state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // read port answers
    assign reg_rd_data = st_q.rd_data;
    assign reg_rd_valid = st_q.rd_valid;
    assign reg_next_addr = st_q.next_addr;
    assign reg_wr_ack = st_q.wr_ack;

    // queue levels
    assign stored_sample_count = st_q.count;
    assign watermark_flag = st_q.wmrk;
    assign queue_overflow_flag = st_q.ovf;

endmodule

// ===== verification/view_checker.sv
// concurrent checks on the output register view
`timescale 1ns/1ps
module view_checker
    import accel_out_pkg::*;
#(
    parameter logic [COUNT_W-1:0] DEPTH = QUEUE_DEPTH
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input accel_triple_t sample_in,
    input view_config_t view_cfg,
    input wire logic queue_push,
    input wire logic queue_pop,
    input wire logic queue_flush,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input logic [7:0] reg_rd_data,
    input logic [7:0] reg_next_addr,
    input logic reg_wr_ack,
    input logic [COUNT_W-1:0] stored_sample_count,
    input logic watermark_flag,
    input logic queue_overflow_flag
);
    // sample the view should be showing
    accel_triple_t lat_q;
    wire le = !view_cfg.byte_order_select && !view_cfg.fast_read_select;
    wire on = view_cfg.queue_mode != QUEUE_MODE_OFF;
    always_ff @(posedge core_clk) begin
        if (rst)
            lat_q <= '0;
        else if (sample_valid)
            lat_q <= sample_in;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_rd(a);
        reg_rd_en && reg_addr == a;
    endsequence
    property p_le;
        s_rd(ADDR_X_HIGH) ##0 le
            |=> reg_rd_data == {{4{$past(lat_q.x[11])}}, $past(lat_q.x[11:8])};
    endproperty
    property p_be;
        s_rd(ADDR_Z_HIGH) ##0 view_cfg.byte_order_select
            |=> reg_rd_data == {$past(lat_q.z[3:0]), NIBBLE_ZERO};
    endproperty
    property p_off;
        s_rd(ADDR_QUEUE_STATE) ##0 !on |=> reg_rd_data == 8'h00;
    endproperty
    property p_state;
        s_rd(ADDR_QUEUE_STATE) ##0 on && !queue_push && !queue_pop && !queue_flush
            |=> reg_rd_data == {watermark_flag, queue_overflow_flag, stored_sample_count};
    endproperty
    property p_fast;
        s_rd(ADDR_Y_LOW) ##0 view_cfg.fast_read_select
            |=> reg_next_addr == ADDR_Z_LOW && reg_rd_data == $past(lat_q.y[11:4]);
    endproperty
    property p_wm;
        !$past(rst) |-> watermark_flag ==
            ($past(on) && stored_sample_count >= $past(view_cfg.watermark_level));
    endproperty
    property p_ovf;
        queue_push && !queue_pop && !queue_flush && on && stored_sample_count == DEPTH
            |=> stored_sample_count == DEPTH && queue_overflow_flag;
    endproperty
    property p_sx;
        s_rd(ADDR_Y_HIGH) ##0 le |=> reg_rd_data[7:4] == {4{reg_rd_data[3]}};
    endproperty
    property p_wr;
        reg_wr_en && !reg_rd_en |=> reg_wr_ack && $stable(reg_rd_data);
    endproperty
    a_le: assert property (p_le) else $error("le high byte");
    a_be: assert property (p_be) else $error("be low nibble");
    a_off: assert property (p_off) else $error("state not zero");
    a_state: assert property (p_state) else $error("state layout");
    a_fast: assert property (p_fast) else $error("fast read");
    a_wm: assert property (p_wm) else $error("watermark");
    a_ovf: assert property (p_ovf) else $error("overflow");
    a_sx: assert property (p_sx) else $error("sign fill");
    a_wr: assert property (p_wr) else $error("write effect");
endmodule
bind accel_output_register_format view_checker #(.DEPTH(DEPTH)) chk (.*);

// ===== verification/host_model.sv
// host model issuing register accesses
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic reg_rd_en = 1'b0,
    output logic reg_wr_en = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wr_data = 8'h00,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_ack
);
    // one access held for one edge, answer taken at the following edge
    task automatic acc(input logic w, input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk);
        reg_rd_en <= !w;
        reg_wr_en <= w;
        reg_addr <= a;
        reg_wr_data <= 8'h5a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= 8'ha5;
        @(posedge core_clk);
        d = reg_rd_data;
        v = w ? reg_wr_ack : reg_rd_valid;
    endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the output register view
`timescale 1ns/1ps
module tb_top;
    import accel_out_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    logic queue_push = 1'b0;
    logic queue_pop = 1'b0;
    logic queue_flush = 1'b0;
    accel_triple_t sample_in = '0;
    view_config_t view_cfg = '0;
    logic reg_rd_en, reg_wr_en, reg_rd_valid, reg_wr_ack, watermark_flag, queue_overflow_flag, v;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, reg_next_addr, d;
    logic [COUNT_W-1:0] stored_sample_count;
    logic [15:0] e;
    int num_errors = 0;
    int samples_checked = 0;
    accel_output_register_format dut (.*);
    host_model h (.*);
    initial forever #2 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, x, s);
        end
    endtask
    // read a register and compare data, valid and optionally next address
    task automatic rc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] n);
        h.acc(1'b0, a, d, v);
        chk("valid", 8'h01, {7'h0, v});
        chk($sformatf("reg %h", a), x, d);
        if (n != 8'h00)
            chk("next", n, reg_next_addr);
    endtask
    // expected {low, high} byte pair of one axis
    function automatic logic [15:0] fmt(input logic [11:0] s, input logic split);
        return split ? {s[11:4], s[3:0], 4'h0} : {s[7:0], {4{s[11]}}, s[11:8]};
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rc(ADDR_QUEUE_STATE, QUEUE_STATE_RESET, 8'h00);
        sample_in <= {12'h8f0, 12'h123, 12'h9a5};
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        // little-endian, big-endian, fast read
        for (int m = 0; m < 3; m++) begin
            view_cfg <= {m == 1, m == 2, 8'h00};
            for (int k = 0; k < 3; k++) begin
                e = fmt(sample_in[12*k +: 12], m != 0);
                rc(ADDR_X_LOW + 8'(2*k), e[15:8], ADDR_X_LOW + 8'(2*k + 1 + (m == 2)));
                if (m != 2)
                    rc(ADDR_X_HIGH + 8'(2*k), e[7:0], 8'h00);
            end
        end
        $display("test byte layout done");
        h.acc(1'b1, ADDR_X_LOW, d, v);
        chk("wr_ack", 8'h01, {7'h0, v});
        rc(ADDR_X_LOW, 8'h9a, 8'h00);
        $display("test write ignored done");
        view_cfg <= {2'b00, 2'b01, 6'd2};
        queue_push <= 1'b1;
        repeat (33) @(posedge core_clk);
        queue_push <= 1'b0;
        rc(ADDR_QUEUE_STATE, 8'he0, 8'h00);
        chk("flags", 8'he0, {watermark_flag, queue_overflow_flag, stored_sample_count});
        queue_pop <= 1'b1;
        @(posedge core_clk);
        queue_pop <= 1'b0;
        rc(ADDR_QUEUE_STATE, 8'h9f, 8'h00);
        chk("flags", 8'h9f, {watermark_flag, queue_overflow_flag, stored_sample_count});
        view_cfg <= {2'b00, 2'b01, 6'd32};
        rc(ADDR_QUEUE_STATE, 8'h1f, 8'h00);
        queue_flush <= 1'b1;
        @(posedge core_clk);
        queue_flush <= 1'b0;
        view_cfg <= {2'b00, 2'b01, 6'd0};
        rc(ADDR_QUEUE_STATE, 8'h80, 8'h00);
        view_cfg <= '0;
        rc(ADDR_QUEUE_STATE, 8'h00, 8'h00);
        $display("test queue state done");
        end_sim();
    end
endmodule
